// File: testbench/sas_analog_model.sv
// multiplexer and comparator model of the analog side
`timescale 1ns/1ps
module sas_analog_model (
	input  wire logic              core_clk,
	input  wire logic [15:0][10:0] levels,
	input  wire logic [3:0]        mux_channel,
	input  wire logic              analog_enable,
	input  wire logic [9:0]        dac_code,
	output logic                   comparator_high
);
	logic flip = 1'b0;
	always @(posedge core_clk) flip <= ~flip;
	// powered down the comparator output is junk
	assign comparator_high = analog_enable ?
		levels[mux_channel] >= {1'b0, dac_code} : flip;
endmodule : sas_analog_model

// File: testbench/sas_sequencer_bench.sv
// self-checking bench for the sar adc sequencer
`timescale 1ns/1ps
module sas_sequencer_bench;
	import sas_pkg::*;
	logic core_clk = 0, rst_n = 0, reg_write = 0, reg_read = 0;
	logic done_irq_enable = 1, halt_mode = 0, comparator_high, sample_hold, analog_enable, irq;
	logic long_sample_select = 0;
	logic [1:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata, d;
	logic [3:0] mux_channel;
	logic [9:0] dac_code;
	logic [15:0][10:0] levels;
	int bad_count = 0, check_count = 0, n, t0;
	always #2.5 core_clk = ~core_clk;
	sas_sequencer #(.SAMPLE_CYCLES(SAMPLE_TICKS), .LONG_SAMPLE_CYCLES(LONG_SAMPLE_TICKS)) uut (
		.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .done_irq_enable(done_irq_enable),
		.long_sample_select(long_sample_select),
		.halt_mode(halt_mode), .comparator_high(comparator_high), .mux_channel(mux_channel),
		.sample_hold(sample_hold), .analog_enable(analog_enable), .dac_code(dac_code), .irq(irq));
	sas_analog_model model (.core_clk(core_clk), .levels(levels), .mux_channel(mux_channel),
		.analog_enable(analog_enable), .dac_code(dac_code), .comparator_high(comparator_high));
	task wrap_up;
		$display("mismatches %0d checks %0d", bad_count, check_count);
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a; reg_wdata <= v; reg_write <= 1;
		@(posedge core_clk);
		reg_write <= 0;
	endtask : wr
	task rd(input logic [1:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1;
		@(posedge core_clk);
		reg_read <= 0;
		// data stand in the cycle after the strobe; take them at its closing edge
		@(posedge core_clk);
		d = reg_rdata;
	endtask : rd
	task wait_irq;
		@(posedge core_clk);
		for (n = 0; irq !== 1'b1; n++) begin
			if (n > 5000) begin
				bad_count++;
				wrap_up;
			end
			@(posedge core_clk);
		end
	endtask : wait_irq
	initial begin
		#500_000;
		bad_count++;
		wrap_up;
	end
	initial begin
		for (int i = 0; i < 16; i++) levels[i] = 11'(i * 64);
		levels[5] = 11'h2a7; levels[15] = 11'h7ff;
		repeat (20) @(posedge core_clk);
		rst_n <= 1;
		for (int a = 0; a < 4; a++) begin rd(2'(a)); chk(d, RESET_BYTE); end
		wr(ADDR_CONTROL_STATUS, 8'hff);
		rd(ADDR_CONTROL_STATUS); chk(d, 8'h7f);
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_CONTROL_STATUS, 8'(p * 32 + 21));
			wait_irq; wait_irq;
			t0 = p == 0 ? DIV_4_MHZ : p == 1 ? DIV_2_MHZ : DIV_1_MHZ;
			chk(8'(n + 1 >= 12 * t0 && n + 1 <= 16 * t0), 8'h01);
		end
		rd(ADDR_RESULT_LOW); chk(d, 8'h03);
		rd(ADDR_RESULT_HIGH); chk(d, 8'ha9);
		rd(ADDR_CONTROL_STATUS); chk(d, 8'h75);
		for (int c = 0; c < 16; c += 5) begin
			wr(ADDR_CONTROL_STATUS, 8'(16 + c)); wait_irq;
			t0 = levels[c] > 1023 ? 1023 : levels[c];
			rd(ADDR_RESULT_LOW); chk(d, 8'(t0 & 3));
			rd(ADDR_RESULT_HIGH); chk(d, 8'(t0 >> 2));
		end
		// low read locks the full-scale sample while channel zero converts
		wait_irq; rd(ADDR_RESULT_LOW); chk(d, 8'h03);
		wr(ADDR_CONTROL_STATUS, 8'h10); wait_irq; wait_irq;
		rd(ADDR_RESULT_HIGH); chk(d, 8'hff);
		wait_irq; rd(ADDR_RESULT_LOW); rd(ADDR_RESULT_HIGH); chk(d, 8'h00);
		rd(ADDR_RESULT_LOW);
		wr(ADDR_CONTROL_STATUS, 8'h00); wr(ADDR_CONTROL_STATUS, 8'h1f); wait_irq;
		rd(ADDR_RESULT_HIGH); chk(d, 8'hff);
		halt_mode <= 1;
		repeat (3) @(posedge core_clk);
		chk(8'(analog_enable), 8'h00);
		halt_mode <= 0; done_irq_enable <= 0; t0 = 0;
		repeat (900) begin @(posedge core_clk); t0 += irq; end
		chk(8'(t0), 8'h00);
		rd(ADDR_CONTROL_STATUS); chk(8'(d[BIT_DONE]), 8'h01);
		// high impedance sources: stretched sample phase
		long_sample_select <= 1;
		done_irq_enable <= 1;
		wait_irq; wait_irq;
		chk(8'(n + 1 == (LONG_SAMPLE_TICKS + RESULT_BITS) * DIV_4_MHZ), 8'h01);
		wrap_up;
	end
endmodule : sas_sequencer_bench
bind sas_sequencer sas_sequencer_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES),
	.LONG_SAMPLE_CYCLES(LONG_SAMPLE_CYCLES)) chk_i (.core_clk(core_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .done_irq_enable(done_irq_enable), .halt_mode(halt_mode),
	.sample_hold(sample_hold), .analog_enable(analog_enable), .irq(irq));

// File: testbench/sas_sequencer_sva.sv
// port assertions for the sar adc sequencer
`timescale 1ns/1ps
module sas_sequencer_sva
	import sas_pkg::*;
#(
	parameter int SAMPLE_CYCLES      = 3,
	parameter int LONG_SAMPLE_CYCLES = 12
) (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       done_irq_enable,
	input wire logic       halt_mode,
	input wire logic       sample_hold,
	input wire logic       analog_enable,
	input wire logic       irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_low_pad: assert property (
		$past(reg_read && reg_addr == ADDR_RESULT_LOW) |-> reg_rdata[7:2] == 6'h00)
		else $error("low result upper bits set");
	chk_unmapped_zero: assert property (
		$past(reg_read && reg_addr == 2'h3) |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_irq_pulse: assert property (irq |=> !irq)
		else $error("irq longer than one cycle");
	chk_irq_enable: assert property (
		irq |-> done_irq_enable || $past(done_irq_enable))
		else $error("irq while disabled");
	chk_sample_on: assert property (sample_hold |-> analog_enable)
		else $error("sampling while off");
	chk_halt_off: assert property (halt_mode |=> !analog_enable)
		else $error("running in halt");
	chk_off_abort: assert property (
		reg_write && reg_addr == ADDR_CONTROL_STATUS && !reg_wdata[BIT_ON]
		|-> ##[1:2] !analog_enable && !sample_hold) else $error("off did not stop");
	chk_on_start: assert property (
		reg_write && reg_addr == ADDR_CONTROL_STATUS && reg_wdata[BIT_ON] && !halt_mode
		|-> ##[1:3] analog_enable) else $error("on did not start");
endmodule : sas_sequencer_sva

// File: verilog/sas_pkg.sv
// package of constants and types for the sar adc sequencer
//
// Functional notes
// - result is ten bits; high byte holds bits 9:2, low byte bits 1:0.
// - input above upper reference reports all ones, no overflow flag.
// - input below lower reference reports zero in both bytes.
// - setting converter_on starts continuous conversion of the selected channel.
// - clearing converter_on disables the converter and aborts conversion.
// - done flag is not cleared when a conversion starts; only a high result read clears it.
// - completion sets done and loads results, held until next completion.
// - completion raises an interrupt request when done_irq_enable is set.
// - reading the high result clears done; writes cannot change done.
// - channel change mid conversion restarts on the new channel at once.
// - four-bit channel select is a plain binary input index 0 to 15.
// - divider select 00, 01, 10 give 4, 2, 1 MHz converter clock.
// - reading the low result locks both result registers.
// - lock releases on high result read or converter_on clear.
// - while locked no new results are written into the result registers.
// - runs unaffected in wait mode, disabled in halt mode.
// - control register read/write except read-only done; all reset to zero.
package sas_pkg;
	localparam logic [1:0] ADDR_CONTROL_STATUS = 2'h0;
	localparam logic [1:0] ADDR_RESULT_HIGH    = 2'h1;
	localparam logic [1:0] ADDR_RESULT_LOW     = 2'h2;
	localparam logic [7:0] RESET_BYTE          = 8'h00;
	localparam int         BIT_DONE            = 7;
	localparam int         BIT_ON              = 4;
	localparam int         CORE_CLK_MHZ        = 200;
	localparam int         ADC_CLK_4_MHZ       = 4;
	localparam int         ADC_CLK_2_MHZ       = 2;
	localparam int         ADC_CLK_1_MHZ       = 1;
	localparam int         DIV_4_MHZ           = CORE_CLK_MHZ / (2 * ADC_CLK_4_MHZ);
	localparam int         DIV_2_MHZ           = CORE_CLK_MHZ / (2 * ADC_CLK_2_MHZ);
	localparam int         DIV_1_MHZ           = CORE_CLK_MHZ / (2 * ADC_CLK_1_MHZ);
	localparam int         SAMPLE_TICKS        = 3;
	localparam int         LONG_SAMPLE_TICKS   = 12;
	localparam int         RESULT_BITS         = 10;

	typedef struct packed {
		logic       done;
		logic [1:0] clock_divider_select;
		logic       converter_on;
		logic [3:0] channel_select;
	} sas_csr_s;

	typedef enum logic [3:0] {
		SAS_IDLE   = 4'b0001,
		SAS_SAMPLE = 4'b0010,
		SAS_CONV   = 4'b0100,
		SAS_DONE   = 4'b1000
	} sas_state_e;
endpackage : sas_pkg

// File: verilog/sas_sequencer.sv
// sar adc digital sequencer with register port and comparator interface
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module sas_sequencer
	import sas_pkg::*;
#(
	parameter int SAMPLE_CYCLES      = SAMPLE_TICKS,
	parameter int LONG_SAMPLE_CYCLES = LONG_SAMPLE_TICKS
) (
	// clock, reset, enable
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// register port
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	// bits held in the clock control misc register and power state
	input  wire logic       done_irq_enable,
	input  wire logic       long_sample_select,
	input  wire logic       halt_mode,
	// analog side and interrupt request
	input  wire logic       comparator_high,
	output logic      [3:0] mux_channel,
	output logic            sample_hold,
	output logic            analog_enable,
	output logic      [9:0] dac_code,
	output logic            irq
);
	sas_csr_s    csr;
	sas_state_e  state;
	logic [9:0]  result;
	logic [9:0]  trial;
	logic [3:0]  bit_idx;
	logic [7:0]  div_cnt;
	logic [7:0]  div_limit;
	logic        adc_tick;
	logic [4:0]  phase_cnt;
	logic        locked;
	logic        cmp_meta;
	logic        cmp_sync;
	logic        running;
	logic        restart;
	logic        finish;
	logic        rd_high;
	logic        rd_low;
	logic        wr_csr;
	logic [4:0]  sample_len;

	assign wr_csr   = reg_write && reg_addr == ADDR_CONTROL_STATUS;
	assign rd_high  = reg_read && reg_addr == ADDR_RESULT_HIGH;
	assign rd_low   = reg_read && reg_addr == ADDR_RESULT_LOW;
	assign running  = csr.converter_on && !halt_mode;
	// a channel change restarts sampling at once
	assign restart  = wr_csr && (reg_wdata[3:0] != csr.channel_select);
	assign finish   = state == SAS_CONV && adc_tick && bit_idx == 4'h0;
	assign sample_len = long_sample_select ? 5'(LONG_SAMPLE_CYCLES)
		: 5'(SAMPLE_CYCLES);

	// divider select to half-period count
	always_comb begin
		case (csr.clock_divider_select)
			2'b00:   div_limit = 8'(DIV_4_MHZ - 1);
			2'b01:   div_limit = 8'(DIV_2_MHZ - 1);
			default: div_limit = 8'(DIV_1_MHZ - 1);
		endcase
	end

	// comparator is asynchronous to the core clock
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else if (clk_en) begin
			cmp_meta <= comparator_high;
			cmp_sync <= cmp_meta;
		end
	end

	// converter clock tick generator
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt  <= 8'h00;
			adc_tick <= 1'b0;
		end else if (clk_en) begin
			if (!running || restart || div_cnt >= div_limit) begin
				div_cnt  <= 8'h00;
				adc_tick <= running && !restart;
			end else begin
				div_cnt  <= div_cnt + 8'h01;
				adc_tick <= 1'b0;
			end
		end
	end

	// control register; the done bit is hardware owned, set wins over the read clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			csr <= sas_csr_s'(RESET_BYTE);
		end else if (clk_en) begin
			if (wr_csr) begin
				csr.clock_divider_select <= reg_wdata[6:5];
				csr.converter_on         <= reg_wdata[BIT_ON];
				csr.channel_select       <= reg_wdata[3:0];
			end
			if (finish && running && !restart)
				csr.done <= 1'b1;
			else if (rd_high)
				csr.done <= 1'b0;
		end
	end

	// conversion sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= SAS_IDLE;
			phase_cnt <= 5'h00;
			bit_idx   <= 4'h0;
			trial     <= 10'h000;
		end else if (clk_en) begin
			if (!running) begin
				state <= SAS_IDLE;
			end else if (restart) begin
				state     <= SAS_SAMPLE;
				phase_cnt <= 5'h00;
			end else begin
				case (state)
					SAS_IDLE: begin
						state     <= SAS_SAMPLE;
						phase_cnt <= 5'h00;
					end
					SAS_SAMPLE: begin
						if (adc_tick) begin
							if (phase_cnt + 5'h01 >= sample_len) begin
								state   <= SAS_CONV;
								bit_idx <= 4'(RESULT_BITS - 1);
								trial   <= 10'h200;
							end else begin
								phase_cnt <= phase_cnt + 5'h01;
							end
						end
					end
					SAS_CONV: begin
						// keep the bit if the input is at or above the trial code
						if (adc_tick) begin
							if (!cmp_sync)
								trial[bit_idx] <= 1'b0;
							if (bit_idx == 4'h0) begin
								state <= SAS_DONE;
							end else begin
								trial[bit_idx - 4'h1] <= 1'b1;
								bit_idx <= bit_idx - 4'h1;
							end
						end
					end
					SAS_DONE: begin
						state     <= SAS_SAMPLE;
						phase_cnt <= 5'h00;
					end
					default: state <= SAS_IDLE;
				endcase
			end
		end
	end

	// result lock
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			locked <= 1'b0;
		end else if (clk_en) begin
			if (rd_high || !csr.converter_on)
				locked <= 1'b0;
			else if (rd_low)
				locked <= 1'b1;
		end
	end

	// result register, final bit resolved on the finishing tick
	// a low read in the same cycle also holds it, so both bytes come from one sample
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			result <= 10'h000;
		end else if (clk_en && finish && running && !restart && !locked && !rd_low) begin
			result <= {trial[9:1], cmp_sync};
		end
	end

	// interrupt request pulse
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= finish && running && !restart && done_irq_enable;
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			if (reg_read) begin
				case (reg_addr)
					ADDR_CONTROL_STATUS: reg_rdata <= csr;
					ADDR_RESULT_HIGH:    reg_rdata <= result[9:2];
					ADDR_RESULT_LOW:     reg_rdata <= {6'h00, result[1:0]};
					default:             reg_rdata <= 8'h00;
				endcase
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// analog side drive
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mux_channel   <= 4'h0;
			sample_hold   <= 1'b0;
			analog_enable <= 1'b0;
			dac_code      <= 10'h000;
		end else if (clk_en) begin
			mux_channel   <= csr.channel_select;
			sample_hold   <= running && state == SAS_SAMPLE;
			analog_enable <= running;
			dac_code      <= trial;
		end
	end
endmodule : sas_sequencer
